// ==== design/gate_timing_regs.svh ====
// Offsets, field positions, reset values and counts for the gate timing capture block.
// Included by the design modules; definitions only.
`ifndef GATE_TIMING_REGS_SVH
`define GATE_TIMING_REGS_SVH

`define TURN_OFF_GATE_TIMING_OFS 5'h1C
`define TURN_ON_GATE_TIMING_OFS 5'h1D
`define GATE_TIMING_RESET 16'hFF01
`define COUNT_MSB 15
`define COUNT_LSB 8
`define ARMED_BIT 7
`define MSG_INVALID_BIT 1
`define PARITY_BIT 0
`define COUNT_RESET 8'hFF
`define COUNT_MAX 8'hFF

`endif

// ==== design/gate_timing_pkg.sv ====
// Types shared by the gate timing capture block.
// Constants live in gate_timing_regs.svh.
package gate_timing_pkg;

  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_ARMED,
    CAP_RUN
  } capState_t;

endpackage : gate_timing_pkg

// ==== design/timing_capture_channel.sv ====
// One capture channel: arm, clear, count while the gate transition runs, hold.
// Assumes request, start and done are one-cycle pulses synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "gate_timing_regs.svh"

module timing_capture_channel (
  input wire logic clk,              // 20 MHz secondary clock
  input wire logic resetn,           // Synchronous reset, active low
  input wire logic captureRequest,   // Pulse: arm, or disarm if already armed
  input wire logic measureStart,     // Pulse: gate transition begins
  input wire logic measureEnd,       // Pulse: gate transition finished
  output logic [7:0] transitionCount, // Captured count
  output logic captureArmed          // Arming flag
);

  gate_timing_pkg::capState_t state_q, state_d;
  logic [7:0] count_q, count_d;

  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    unique case (state_q)
      gate_timing_pkg::CAP_IDLE:
      begin
        if (captureRequest)
          state_d = gate_timing_pkg::CAP_ARMED;
      end
      gate_timing_pkg::CAP_ARMED:
      begin
        if (captureRequest)
          state_d = gate_timing_pkg::CAP_IDLE;
        else if (measureStart)
        begin
          count_d = 8'h00;
          state_d = gate_timing_pkg::CAP_RUN;
        end
      end
      gate_timing_pkg::CAP_RUN:
      begin
        if (captureRequest)
          state_d = gate_timing_pkg::CAP_IDLE;
        else if (measureEnd)
          state_d = gate_timing_pkg::CAP_IDLE;
        else if (count_q != `COUNT_MAX)
          count_d = count_q + 8'h01; // saturates rather than wrap
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q <= gate_timing_pkg::CAP_IDLE;
      count_q <= `COUNT_RESET;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign transitionCount = count_q;
  assign captureArmed = (state_q != gate_timing_pkg::CAP_IDLE);

endmodule : timing_capture_channel

`default_nettype wire

// ==== design/gate_switching_timing_capture.sv ====
// Behaviour
// - Turn-off gate duration is captured into bits 15:8 of the turn-off timing register.
// - Turn-on gate duration is captured into bits 15:8 of the turn-on timing register.
// - A channel's count clears to zero when its measurement begins.
// - Bit 7 of each register reads one while that channel is armed or measuring.
// - The arming flag clears when the measurement completes.
// - A new request while armed clears the flag and disarms instead of restarting.
// - Bit 1 of every returned word is one if the previous message was discarded.
// - Bit 0 of every returned word makes the whole word odd parity.
//
// Gate switching timing capture: two channels and the read-only word mux.
// Assumes the serial front end supplies a register address, a read strobe and the
// discard status of the previous message; all inputs synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "gate_timing_regs.svh"

module gate_switching_timing_capture (
  input wire logic clk,                // 20 MHz secondary clock
  input wire logic resetn,             // Synchronous reset, active low
  input wire logic offCaptureRequest,  // Pulse: arm or disarm turn-off channel
  input wire logic offMeasureStart,    // Pulse: turn-off transition begins
  input wire logic offMeasureEnd,      // Pulse: turn-off transition ends
  input wire logic onCaptureRequest,   // Pulse: arm or disarm turn-on channel
  input wire logic onMeasureStart,     // Pulse: turn-on transition begins
  input wire logic onMeasureEnd,       // Pulse: turn-on transition ends
  input wire logic [4:0] regAddr,      // Register offset to read
  input wire logic readStrobe,         // Pulse: latch word for regAddr
  input wire logic lastMessageInvalid, // Previous serial message discarded
  output logic [15:0] readData,        // Returned word, registered
  output logic readHit                 // Registered: last read hit a mapped offset
);

  logic [7:0] offTransitionCount;
  logic [7:0] onTransitionCount;
  logic offCaptureArmed;
  logic onCaptureArmed;
  logic [15:0] readData_q, readData_d;
  logic readHit_q, readHit_d;
  logic [15:0] word;

  timing_capture_channel offChannel (
    .clk(clk),
    .resetn(resetn),
    .captureRequest(offCaptureRequest),
    .measureStart(offMeasureStart),
    .measureEnd(offMeasureEnd),
    .transitionCount(offTransitionCount),
    .captureArmed(offCaptureArmed)
  );

  timing_capture_channel onChannel (
    .clk(clk),
    .resetn(resetn),
    .captureRequest(onCaptureRequest),
    .measureStart(onMeasureStart),
    .measureEnd(onMeasureEnd),
    .transitionCount(onTransitionCount),
    .captureArmed(onCaptureArmed)
  );

  // Unmapped offsets return zero content but still carry status and parity
  always_comb
  begin
    word = 16'h0000;
    readHit_d = 1'b0;
    if (regAddr == `TURN_OFF_GATE_TIMING_OFS)
    begin
      word[`COUNT_MSB:`COUNT_LSB] = offTransitionCount;
      word[`ARMED_BIT] = offCaptureArmed;
      readHit_d = 1'b1;
    end
    else if (regAddr == `TURN_ON_GATE_TIMING_OFS)
    begin
      word[`COUNT_MSB:`COUNT_LSB] = onTransitionCount;
      word[`ARMED_BIT] = onCaptureArmed;
      readHit_d = 1'b1;
    end
    word[`MSG_INVALID_BIT] = lastMessageInvalid;
    word[`PARITY_BIT] = ~(^word[15:1]);
    readData_d = readStrobe ? word : readData_q;
    if (!readStrobe)
      readHit_d = readHit_q;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      readData_q <= `GATE_TIMING_RESET;
      readHit_q <= 1'b0;
    end
    else
    begin
      readData_q <= readData_d;
      readHit_q <= readHit_d;
    end
  end

  assign readData = readData_q;
  assign readHit = readHit_q;

endmodule : gate_switching_timing_capture

`default_nettype wire

// ==== sim/gate_switching_timing_capture_properties.sv ====
// Read port properties of the gate timing capture block.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module gate_timing_checker (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic [4:0] regAddr, // Offset
  input wire logic readStrobe, // Read
  input wire logic lastMessageInvalid, // Discard
  input wire logic [15:0] readData, // Word
  input wire logic readHit // Hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  odd_parity_a: assert property (^readData) else $error("even word");
  discard_echo_a: assert property (readStrobe |=> readData[1] == $past(lastMessageInvalid))
    else $error("discard bit");
  word_hold_a: assert property (!readStrobe |=> $stable(readData)) else $error("drift");
  off_hit_a: assert property (readStrobe && regAddr == 5'h1C |=> readHit) else $error("1C");
  on_hit_a: assert property (readStrobe && regAddr == 5'h1D |=> readHit) else $error("1D");
  miss_word_a: assert property (readStrobe && regAddr < 5'h1C |=> !readHit) else $error("miss");
  reserved_zero_a: assert property (readStrobe |=> readData[6:2] == 5'h00) else $error("rsv");
  reset_word_a: assert property ($rose(resetn) |-> readData == 16'hFF01) else $error("rst");
endmodule : gate_timing_checker
bind gate_switching_timing_capture gate_timing_checker chk (.clk, .resetn, .regAddr,
  .readStrobe, .lastMessageInvalid, .readData, .readHit);
`default_nettype wire

// ==== sim/host_reader.sv ====
// Host model: issues reads on the local read port.
// Assumes reads start after reset, driven off the falling edge.
`timescale 1ns/10ps
`default_nettype none
module host_reader (
  input wire logic clk, // Clock
  input wire logic [15:0] readData, // Word
  output logic [4:0] regAddr, // Offset
  output logic readStrobe // Read
);
  initial {regAddr, readStrobe} = 6'h00;
  task automatic readWord(input logic [4:0] a, output logic [15:0] w);
    @(negedge clk);
    regAddr = a;
    readStrobe = 1'h1;
    @(negedge clk);
    w = readData;
    readStrobe = 1'h0;
    // Inverted so a stale offset cannot pass for a held one
    regAddr = ~a;
  endtask : readWord
endmodule : host_reader
`default_nettype wire

// ==== sim/gate_switching_timing_capture_tb_top.sv ====
// Bench: pulses both channels and reads both words back.
// Assumes the host model for reads; no other driver.
`timescale 1ns/10ps
`default_nettype none
module gate_switching_timing_capture_tb_top;
  logic clk, resetn, lastMessageInvalid, readHit, readStrobe;
  logic [5:0] ev;
  logic [4:0] regAddr;
  logic [15:0] readData;
  int errors, compares;
  gate_switching_timing_capture DUT (.clk, .resetn, .offCaptureRequest(ev[0]),
    .offMeasureStart(ev[1]), .offMeasureEnd(ev[2]), .onCaptureRequest(ev[3]),
    .onMeasureStart(ev[4]), .onMeasureEnd(ev[5]), .regAddr, .readStrobe,
    .lastMessageInvalid, .readData, .readHit);
  host_reader host (.clk, .readData, .regAddr, .readStrobe);
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic pulse(input logic [5:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 6'h00;
  endtask : pulse
  task automatic chk(input logic [16:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Expected word is {count, armed}, zeros, discard bit, odd parity
  task automatic rd(input logic [4:0] a, input logic [8:0] cf, input logic h);
    logic [15:0] w;
    host.readWord(a, w);
    chk({readHit, w}, {h, cf, 5'h00, lastMessageInvalid, ~^{cf, lastMessageInvalid}});
  endtask : rd
  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial
  begin
    {resetn, lastMessageInvalid, ev} = 8'h00;
    repeat (8) @(negedge clk);
    resetn = 1'h1;
    rd(5'h1C, 9'h1FE, 1'h1);
    rd(5'h1D, 9'h1FE, 1'h1);
    pulse(6'h01);
    rd(5'h1C, 9'h1FF, 1'h1);
    pulse(6'h02);
    rd(5'h1C, 9'h003, 1'h1);
    pulse(6'h04);
    lastMessageInvalid = 1'h1;
    rd(5'h1C, 9'h006, 1'h1);
    pulse(6'h08);
    pulse(6'h08);
    pulse(6'h10);
    pulse(6'h20);
    rd(5'h1D, 9'h1FE, 1'h1);
    pulse(6'h08);
    pulse(6'h10);
    pulse(6'h20);
    rd(5'h1D, 9'h002, 1'h1);
    rd(5'h00, 9'h000, 1'h0);
    wrap_up();
  end
  initial
  begin
    #20000;
    errors++;
    wrap_up();
  end
endmodule : gate_switching_timing_capture_tb_top
`default_nettype wire
